//--- design/timer_counter.v
// What this block does
// R01: Sixteen-bit count in two writable bytes
// R02: Count wraps from ffff to zero
// R03: Wrap sets overflow flag regardless of enable
// R04: Interrupt only while overflow enable set
// R05: Control bit 1 picks pin or instruction clock
// R06: Internal source ticks once per instruction cycle
// R07: External source counts rising pin edges
// R08: On bit gates counting, count held
// R09: Event trigger input clears the count
// R10: Oscillator on forces pins input, reads zero
// R11: Prescale field divides by 1,2,4,8
// R12: Oscillator enable bit powers the inverter
// R13: Bit 2 chooses synchronised or raw edges; the raw path still uses the two sync flops, only skipping one history stage
// R14: Flag stays set until software clears it
// R15: Writing a count byte clears prescaler
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "timer_consts.vh"
module timer_counter (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg irq,
  input wire ext_count_pin,
  input wire event_trigger_a,
  input wire event_trigger_b,
  input wire [1:0] port_c_direction,
  input wire [1:0] port_c_pin_in,
  output reg [1:0] port_c_pin_oe,
  output reg [1:0] port_c_read,
  output reg osc_inverter_on
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] count_low_byte_reg; // Low count byte
  reg [7:0] count_high_byte_reg; // High count byte
  reg [7:0] counter_control_reg; // Control bits
  reg overflow_flag_reg; // Sticky overflow
  reg overflow_irq_enable_reg; // Interrupt mask
  reg [1:0] insn_div_reg; // Quarter divider for instruction cycle
  reg pin_meta_reg; // First sync stage, read only by the second
  reg pin_sync_reg; // Second sync stage
  reg pin_prev_reg; // Previous synchronised level
  reg raw_prev_reg; // Extra edge-history stage, used only by the synchronised path
  reg [1:0] pc_meta_reg; // Port pin sync stage one
  reg [1:0] pc_sync_reg; // Port pin sync stage two
  reg trig_meta_reg; // Trigger sync stage one
  reg trig_sync_reg; // Trigger sync stage two
  wire scaled_tick; // Tick after prescaler
  reg raw_tick; // Tick before prescaler
  reg ext_tick; // Edge from pin
  wire bus_write; // APB write access phase
  wire bus_read; // APB read access phase
  wire wr_count; // Either count byte written
  wire wrap; // Count at ffff and advancing
  wire counter_on = counter_control_reg[`CTL_ON_BIT];
  wire src_ext = counter_control_reg[`CTL_SRC_BIT];
  wire no_sync = counter_control_reg[`CTL_NOSYNC_BIT];
  wire osc_en = counter_control_reg[`CTL_OSC_BIT];

  // Address compare used by write and read paths
  function hit;
    input [11:0] a;
    input [11:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // Writes land only at the edge that completes the transfer (pready high)
  assign bus_write = psel && penable && pwrite && pready;
  assign bus_read = psel && penable && !pwrite;
  assign wr_count = bus_write && pstrb[0] &&
    (hit(paddr, `ADDR_COUNT_LOW) || hit(paddr, `ADDR_COUNT_HIGH));

  // ----------------------------------------
  // Pin and trigger synchronisers
  // ----------------------------------------
  // Two flops on the count pin, port C pins and triggers; the synchronised mode adds one more
  // stage of edge history, so the unsynchronised mode reacts a cycle sooner
  always @(posedge core_clk) begin
    if (srst) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
      raw_prev_reg <= 1'b0;
      pc_meta_reg <= 2'h0;
      pc_sync_reg <= 2'h0;
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= ext_count_pin;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
      raw_prev_reg <= pin_prev_reg;
      pc_meta_reg <= port_c_pin_in;
      pc_sync_reg <= pc_meta_reg;
      trig_meta_reg <= event_trigger_a | event_trigger_b; // R09
      trig_sync_reg <= trig_meta_reg;
    end
  end

  // ----------------------------------------
  // Tick source selection
  // ----------------------------------------
  // Unsynchronised mode skips the edge-history flop, so it reacts one cycle
  // sooner; a true asynchronous counter would need a second clock domain
  always @* begin
    if (no_sync)
      ext_tick = pin_sync_reg & ~pin_prev_reg; // R13
    else
      ext_tick = pin_prev_reg & ~raw_prev_reg; // R07
    if (src_ext)
      raw_tick = counter_on & ext_tick; // R05
    else
      raw_tick = counter_on & (insn_div_reg == 2'h3); // R06
  end

  // Instruction-cycle divider, free running
  always @(posedge core_clk) begin
    if (srst)
      insn_div_reg <= 2'h0;
    else
      insn_div_reg <= insn_div_reg + 2'h1;
  end

  prescaler #(
    .WIDTH(3)
  ) u_prescaler (
    .core_clk(core_clk),
    .srst(srst),
    .clear(wr_count),
    .tick_in(raw_tick),
    .ratio(counter_control_reg[`CTL_PS_MSB:`CTL_PS_LSB]),
    .tick_out(scaled_tick)
  );

  // Prescaled tick only counts while enabled, so turning off holds the count
  assign wrap = scaled_tick && counter_on &&
    ({count_high_byte_reg, count_low_byte_reg} == 16'hffff);

  // ----------------------------------------
  // Count and register writes
  // ----------------------------------------
  // Priority: trigger clear, then software write, then increment
  always @(posedge core_clk) begin
    if (srst) begin
      count_low_byte_reg <= 8'h00;
      count_high_byte_reg <= 8'h00;
      counter_control_reg <= `CTL_RESET;
      overflow_irq_enable_reg <= 1'b0;
    end else begin
      if (trig_sync_reg) begin
        count_low_byte_reg <= 8'h00; // R09
        count_high_byte_reg <= 8'h00;
      end else if (wr_count) begin
        if (hit(paddr, `ADDR_COUNT_LOW))
          count_low_byte_reg <= pwdata[7:0]; // R01
        else
          count_high_byte_reg <= pwdata[7:0]; // R01
      end else if (scaled_tick && counter_on) begin // R08
        {count_high_byte_reg, count_low_byte_reg} <=
          {count_high_byte_reg, count_low_byte_reg} + 16'h0001; // R02
      end
      if (bus_write && pstrb[0] && hit(paddr, `ADDR_CONTROL))
        counter_control_reg <= pwdata[7:0] & `CTL_MASK;
      if (bus_write && pstrb[0] && hit(paddr, `ADDR_ENABLE))
        overflow_irq_enable_reg <= pwdata[`FLAG_OVF_BIT];
    end
  end

  // ----------------------------------------
  // Overflow flag and interrupt
  // ----------------------------------------
  // Write one to clear; a wrap in the same cycle wins
  always @(posedge core_clk) begin
    if (srst) begin
      overflow_flag_reg <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (wrap)
        overflow_flag_reg <= 1'b1; // R03
      else if (bus_write && pstrb[0] && hit(paddr, `ADDR_FLAG) &&
               pwdata[`FLAG_OVF_BIT])
        overflow_flag_reg <= 1'b0; // R14
      irq <= (overflow_flag_reg | wrap) & overflow_irq_enable_reg; // R04
    end
  end

  // ----------------------------------------
  // Oscillator pins
  // ----------------------------------------
  // Direction bits are active-low drives; the oscillator overrides them
  always @(posedge core_clk) begin
    if (srst) begin
      port_c_pin_oe <= 2'h0;
      port_c_read <= 2'h0;
      osc_inverter_on <= 1'b0;
    end else begin
      osc_inverter_on <= osc_en; // R12
      if (osc_en) begin
        port_c_pin_oe <= 2'h0; // R10
        port_c_read <= 2'h0; // R10
      end else begin
        port_c_pin_oe <= ~port_c_direction;
        port_c_read <= pc_sync_reg;
      end
    end
  end

  // ----------------------------------------
  // APB slave: one wait state, answer in second access cycle
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= 32'h00000000;
        if (hit(paddr, `ADDR_COUNT_LOW)) begin
          if (bus_read) prdata <= {24'h000000, count_low_byte_reg}; // R01
        end else if (hit(paddr, `ADDR_COUNT_HIGH)) begin
          if (bus_read) prdata <= {24'h000000, count_high_byte_reg};
        end else if (hit(paddr, `ADDR_CONTROL)) begin
          if (bus_read) prdata <= {24'h000000, counter_control_reg};
        end else if (hit(paddr, `ADDR_FLAG)) begin
          if (bus_read) prdata <= {31'h00000000, overflow_flag_reg};
        end else if (hit(paddr, `ADDR_ENABLE)) begin
          if (bus_read) prdata <= {31'h00000000, overflow_irq_enable_reg};
        end else begin
          pslverr <= 1'b1; // Unmapped: error, reads zero
        end
      end
    end
  end
endmodule // timer_counter
`default_nettype wire

//--- shared/timer_consts.vh
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
// ----------------------------------------
// Register byte addresses (index times four)
// ----------------------------------------
`define IDX_COUNT_LOW 8'h0e
`define IDX_COUNT_HIGH 8'h0f
`define IDX_CONTROL 8'h10
`define IDX_FLAG 8'h11
`define IDX_ENABLE 8'h12
`define ADDR_COUNT_LOW 12'h038
`define ADDR_COUNT_HIGH 12'h03c
`define ADDR_CONTROL 12'h040
`define ADDR_FLAG 12'h044
`define ADDR_ENABLE 12'h048
// ----------------------------------------
// Control field positions and reset values
// ----------------------------------------
`define CTL_ON_BIT 0
`define CTL_SRC_BIT 1
`define CTL_NOSYNC_BIT 2
`define CTL_OSC_BIT 3
`define CTL_PS_LSB 4
`define CTL_PS_MSB 5
`define CTL_MASK 8'h3f
`define CTL_RESET 8'h00
`define FLAG_OVF_BIT 0
// Core cycles per instruction cycle (oscillator divided by four)
`define INSN_DIV 4
`endif

//--- design/prescaler.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Prescaler: passes one of every 1, 2, 4 or 8 ticks
// ----------------------------------------
module prescaler #(
  parameter WIDTH = 3
) (
  input wire core_clk,
  input wire srst,
  input wire clear,
  input wire tick_in,
  input wire [1:0] ratio,
  output reg tick_out
);
  reg [WIDTH-1:0] div_reg; // Running tick count

  // Mask for the selected ratio
  function [WIDTH-1:0] ratio_mask;
    input [1:0] sel;
    begin
      case (sel)
        2'b11: ratio_mask = 3'h7;
        2'b10: ratio_mask = 3'h3;
        2'b01: ratio_mask = 3'h1;
        default: ratio_mask = 3'h0;
      endcase
    end
  endfunction

  // Count ticks and emit one on each full period
  always @(posedge core_clk) begin
    if (srst || clear) begin
      div_reg <= {WIDTH{1'b0}}; // R15
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if ((div_reg & ratio_mask(ratio)) == ratio_mask(ratio)) begin
          div_reg <= {WIDTH{1'b0}};
          tick_out <= 1'b1; // R11
        end else begin
          div_reg <= div_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // prescaler
`default_nettype wire

//--- bench/timer_counter_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_consts.vh"
// ----------------------------------------
// Port checks on the timer block
// ----------------------------------------
module timer_counter_chk (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic [1:0] port_c_pin_oe,
  input wire logic [1:0] port_c_read,
  input wire logic osc_inverter_on
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  wire take = psel && penable && !pready; // First access cycle
  wire wr0 = take && pwrite && pstrb[0]; // Write that stores lane 0
  wire known = paddr == `ADDR_COUNT_LOW || paddr == `ADDR_COUNT_HIGH ||
    paddr == `ADDR_CONTROL || paddr == `ADDR_FLAG || paddr == `ADDR_ENABLE;
  logic osc_want = 1'b0; // Bit 3 of the last control write
  always @(posedge core_clk) if (wr0 && paddr == `ADDR_CONTROL) osc_want <= pwdata[3];
  a_ready_next: assert property (take |=> pready)
    else $error("ready missing after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_refuse_unmapped: assert property (take && !known |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_osc_follow: assert property (wr0 && paddr == `ADDR_CONTROL |-> ##[1:3] osc_inverter_on == osc_want)
    else $error("oscillator enable not following");
  a_pins_input: assert property (osc_inverter_on && $past(osc_inverter_on) |-> port_c_pin_oe == 2'b00 && port_c_read == 2'b00)
    else $error("pins not inputs under oscillator");
  a_irq_masked: assert property (wr0 && paddr == `ADDR_ENABLE && !pwdata[0] |-> ##[1:3] !irq)
    else $error("interrupt not masked");
  a_irq_hold: assert property ($fell(irq) |-> $past(psel, 2) || $past(psel, 3))
    else $error("interrupt dropped without a write");
endmodule // timer_counter_chk
`default_nettype wire

//--- bench/ext_clock_src.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// External count clock source, idle low between bursts
// ----------------------------------------
module ext_clock_src (
  input wire logic core_clk,
  input wire logic start,
  input wire logic [7:0] pulses,
  input wire logic [3:0] half,
  output logic pin,
  output logic busy
);
  int n = 0; // Toggles left
  int k = 0; // Cycles left in this half period
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // Each level lasts half cycles, so slow and fast sources are both possible
  always @(posedge core_clk) begin
    if (start && !busy) begin
      busy <= 1'b1;
      n <= 2 * pulses;
      k <= half;
    end else if (busy) begin
      if (k > 1) k <= k - 1;
      else begin
        k <= half;
        pin <= ~pin;
        n <= n - 1;
        if (n == 1) busy <= 1'b0;
      end
    end
  end
endmodule // ext_clock_src
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_consts.vh"
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x); end end
module tb;
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, irq, pin, ta, tb_, osc, go, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic [1:0] dir, pin_in, oe, rd;
  logic e;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  timer_counter DUT (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .ext_count_pin(pin),
    .event_trigger_a(ta), .event_trigger_b(tb_), .port_c_direction(dir),
    .port_c_pin_in(pin_in), .port_c_pin_oe(oe), .port_c_read(rd), .osc_inverter_on(osc));
  ext_clock_src src (.core_clk(core_clk), .start(go), .pulses(8'h0a), .half(4'h3),
    .pin(pin), .busy(busy));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc++;
  // One APB transfer; holds everything until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask
  task t_regs;
    rc(`ADDR_CONTROL, 32'h0);
    rc(`ADDR_COUNT_LOW, 32'h0);
    wr(`ADDR_COUNT_LOW, 32'h5a); wr(`ADDR_COUNT_HIGH, 32'ha5);
    rc(`ADDR_COUNT_LOW, 32'h5a);
    rc(`ADDR_COUNT_HIGH, 32'ha5);
    wr(`ADDR_CONTROL, 32'hc6); rc(`ADDR_CONTROL, 32'h06);
    apb(1'b0, 12'h0fc, 32'h0); `CHK(e, 1'b1)
  endtask
  task t_prescale;
    int s;
    for (int p = 0; p < 4; p++) begin
      wr(`ADDR_COUNT_LOW, 32'h0); wr(`ADDR_COUNT_HIGH, 32'h0);
      s = cyc; wr(`ADDR_CONTROL, p * 16 + 1);
      while (cyc < s + 18 * (1 << p)) @(posedge core_clk);
      wr(`ADDR_CONTROL, p * 16); apb(1'b0, `ADDR_COUNT_LOW, 32'h0);
      `CHK(q == 32'h4 || q == 32'h5, 1'b1)
      repeat (20) @(posedge core_clk);
      rc(`ADDR_COUNT_LOW, q);
    end
  endtask
  task t_wrap;
    wr(`ADDR_ENABLE, 32'h0); wr(`ADDR_COUNT_LOW, 32'hfe); wr(`ADDR_COUNT_HIGH, 32'hff);
    wr(`ADDR_CONTROL, 32'h1); repeat (30) @(posedge core_clk); wr(`ADDR_CONTROL, 32'h0);
    rc(`ADDR_COUNT_HIGH, 32'h0);
    rc(`ADDR_FLAG, 32'h1); `CHK(irq, 1'b0)
    wr(`ADDR_ENABLE, 32'h1); @(posedge core_clk);
    `CHK(irq, 1'b1)
    wr(`ADDR_ENABLE, 32'h0); @(posedge core_clk);
    `CHK(irq, 1'b0)
    wr(`ADDR_ENABLE, 32'h1); rc(`ADDR_FLAG, 32'h1);
    wr(`ADDR_FLAG, 32'h1); @(posedge core_clk);
    `CHK(irq, 1'b0)
    rc(`ADDR_FLAG, 32'h0);
  endtask
  task t_ext;
    for (int s = 0; s < 2; s++) begin
      wr(`ADDR_COUNT_LOW, 32'h0); wr(`ADDR_CONTROL, 32'h13 + s * 4);
      go <= 1'b1; @(posedge core_clk) go <= 1'b0; @(posedge core_clk);
      while (busy) @(posedge core_clk);
      repeat (6) @(posedge core_clk); wr(`ADDR_CONTROL, 32'h0);
      rc(`ADDR_COUNT_LOW, 32'h5);
    end
  endtask
  task t_trig_osc;
    for (int i = 1; i < 3; i++) begin
      wr(`ADDR_COUNT_LOW, 32'h20); {tb_, ta} <= i; repeat (4) @(posedge core_clk);
      {tb_, ta} <= 2'b00; repeat (4) @(posedge core_clk);
      rc(`ADDR_COUNT_LOW, 32'h0);
    end
    wr(`ADDR_CONTROL, 32'h08); repeat (3) @(posedge core_clk);
    `CHK({osc, oe, rd}, 5'h10)
    wr(`ADDR_CONTROL, 32'h0); repeat (3) @(posedge core_clk);
    `CHK({osc, oe, rd}, 5'h0f)
  endtask
  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {srst, psel, penable, pwrite, ta, tb_, go} = 7'h40; paddr = 12'h0; pwdata = 32'h0;
    pstrb = 4'hf; dir = 2'b00; pin_in = 2'b11;
    repeat (4) @(posedge core_clk); srst <= 1'b0; @(posedge core_clk);
    t_regs; t_prescale; t_wrap; t_ext; t_trig_osc;
    tally_and_finish;
  end
  // Cuts a hang short; the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule // tb
bind timer_counter timer_counter_chk u_chk (.core_clk(core_clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .port_c_pin_oe(port_c_pin_oe), .port_c_read(port_c_read), .osc_inverter_on(osc_inverter_on));
`default_nettype wire
